// ==== rtl/rbms_cfg.svh ====
// Constants for the reset boot mode selector: offsets, fields, counts.
// Assumes inclusion by bare name from the package and the top module.
`ifndef RBMS_CFG_SVH
`define RBMS_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define RBMS_CTRL_OFF 12'h000
`define RBMS_STAT_OFF 12'h004
`define RBMS_FLAG_OFF 12'h008

// ****************************************************************
// Field positions
// ****************************************************************
`define RBMS_CTRL_BYTE_GO 0
`define RBMS_CTRL_PM0_WR 1
`define RBMS_FLAG_OUT 0
`define RBMS_FLAG_OE 1
`define RBMS_FLAG_IN 2

// ****************************************************************
// Counts and reset values
// ****************************************************************
`define RBMS_BOOT_WORDS 32
`define RBMS_BYTE_ADDR_W 22
`define RBMS_HOST_W 16
`define RBMS_RESP_OK 2'b00
`define RBMS_RESP_ERR 2'b10

`endif

// ==== rtl/rbms_pkg.sv ====
// Types for the reset boot mode selector.
// Assumes the constants header sits beside it.
`include "rbms_cfg.svh"

package rbms_pkg;

    // ****************************************************************
    // Decoded boot mode and state
    // ****************************************************************
    typedef enum logic [3:0] {
        RBMS_BOOT_BYTE = 4'b0001,
        RBMS_BOOT_NONE = 4'b0010,
        RBMS_BOOT_HOST = 4'b0100,
        RBMS_BOOT_BAD = 4'b1000
    } rbms_boot_e;

    typedef enum logic [2:0] {
        RBMS_ST_LOAD = 3'b001,
        RBMS_ST_WAIT = 3'b010,
        RBMS_ST_RUN = 3'b100
    } rbms_state_e;

    // Latched strap set
    typedef struct packed {
        logic mode_d;
        logic mode_c;
        logic mode_b;
        logic mode_a;
    } rbms_strap_s;

    // Configuration seen by the rest of the core
    typedef struct packed {
        logic host_port_cfg;
        logic ack_open_drain;
        logic [`RBMS_HOST_W-1:0] start_addr;
    } rbms_cfg_s;

endpackage : rbms_pkg

// ==== rtl/rbms_top.sv ====
// Reset boot mode selector: strap latch, boot sequencing, bus routing, AXI4-Lite regs.
// Assumes straps settle before RST_B rises and that the byte DMA engine and host
// port logic sit outside, reporting word completion and program location 0 writes.
// Notes on behaviour
// - Boot configuration comes from strap pins during reset, never from software.
// - Strap C pin becomes a general-purpose flag, input or output, after reset.
// - Straps 000: byte DMA copies 32 program words, external-bus configuration.
// - Byte DMA boot holds execution until all 32 words are copied.
// - Straps 010: no boot, start at external address 0, external-bus configuration.
// - No-boot mode: byte DMA usable by software, never started or awaited.
// - Straps 100: 32-word byte DMA boot in host-port configuration.
// - Straps 101: host loads memory; execution waits for program location 0 write.
// - Host-port with strap D low: acknowledge actively driven both levels.
// - Host-port with strap D high: acknowledge never driven low; external pull-down.
// - Strap D ignored whenever strap C is low.
// - Host-port configuration replaces external buses with 16-bit multiplexed host port.
// - Host port reaches on-chip program and data RAM without processor involvement.
// - External-bus configuration shares one address bus and one data bus.
// - Byte DMA port is bidirectional, addressing up to four megabytes.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

`include "rbms_cfg.svh"

module rbms_top
    import rbms_pkg::*;
#(
    parameter int BOOT_WORDS = `RBMS_BOOT_WORDS
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Strap pins
    input wire logic MODE_A,
    input wire logic MODE_B,
    input wire logic MODE_D,
    // Shared flag pin (strap C during reset)
    input wire logic SHARED_FLAG_PIN_I,
    output logic SHARED_FLAG_PIN_O,
    output logic SHARED_FLAG_PIN_OE,
    // Byte DMA boot engine handshake
    input wire logic BYTE_DMA_WORD_DONE,
    output logic BYTE_DMA_BOOT_REQ,
    output logic BYTE_DMA_SW_GO,
    // Host port events and acknowledge
    input wire logic HOST_PM0_WRITE,
    input wire logic HOST_ACK_REQ,
    output logic HOST_ACCESS_ACK_O,
    output logic HOST_ACCESS_ACK_OE,
    // Core-facing configuration and execution hold
    output rbms_cfg_s CORE_CFG,
    output logic CORE_RUN,
    // Internal bus sources for external-bus sharing
    input wire logic CORE_PM_SEL,
    input wire logic [`RBMS_HOST_W-1:0] PROGRAM_ADDR_BUS,
    input wire logic [`RBMS_HOST_W-1:0] DATA_ADDR_BUS,
    input wire logic [`RBMS_HOST_W-1:0] PROGRAM_DATA_BUS,
    input wire logic [`RBMS_HOST_W-1:0] DATA_MEM_DATA_BUS,
    output logic [`RBMS_HOST_W-1:0] EXT_ADDR,
    output logic [`RBMS_HOST_W-1:0] EXT_DATA,
    output logic EXT_BUS_EN,
    output logic HOST_PORT_EN,
    // AXI4-Lite slave
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // ****************************************************************
    // Strap capture
    // ****************************************************************
    rbms_strap_s strap_reg;
    logic cap_pend_reg;
    rbms_boot_e boot_mode;
    rbms_state_e state_reg;
    logic [5:0] word_cnt_reg;
    logic flag_out_reg;
    logic flag_oe_reg;
    logic sw_go_reg;

    // Decode straps to a boot mode, D dropped
    function automatic rbms_boot_e decode_boot(input rbms_strap_s s);
        unique case ({s.mode_c, s.mode_b, s.mode_a})
            3'b000, 3'b100: decode_boot = RBMS_BOOT_BYTE;
            3'b010: decode_boot = RBMS_BOOT_NONE;
            3'b101: decode_boot = RBMS_BOOT_HOST;
            default: decode_boot = RBMS_BOOT_BAD;
        endcase
    endfunction : decode_boot

    // Capture on first clock after release
    // Straps, not software
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cap_pend_reg <= 1'b1;
            strap_reg <= '0;
        end else if (cap_pend_reg) begin
            cap_pend_reg <= 1'b0;
            strap_reg <= '{mode_d: MODE_D, mode_c: SHARED_FLAG_PIN_I, mode_b: MODE_B, mode_a: MODE_A};
        end
    end

    assign boot_mode = decode_boot(strap_reg);

    // ****************************************************************
    // Boot sequencer
    // ****************************************************************
    // Hold execution until the chosen boot condition
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= RBMS_ST_LOAD;
            word_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                RBMS_ST_LOAD: begin
                    if (!cap_pend_reg) begin
                        state_reg <= RBMS_ST_WAIT;
                    end
                end
                RBMS_ST_WAIT: begin
                    unique case (boot_mode)
                        RBMS_BOOT_BYTE: begin
                            if (BYTE_DMA_WORD_DONE) begin
                                word_cnt_reg <= word_cnt_reg + 6'd1;
                                if (word_cnt_reg == 6'(BOOT_WORDS - 1)) begin
                                    state_reg <= RBMS_ST_RUN;
                                end
                            end
                        end
                        RBMS_BOOT_NONE: state_reg <= RBMS_ST_RUN;
                        RBMS_BOOT_HOST: begin
                            if (HOST_PM0_WRITE) begin
                                state_reg <= RBMS_ST_RUN;
                            end
                        end
                        default: state_reg <= RBMS_ST_WAIT;
                    endcase
                end
                RBMS_ST_RUN: state_reg <= RBMS_ST_RUN;
            endcase
        end
    end

    assign BYTE_DMA_BOOT_REQ = (state_reg == RBMS_ST_WAIT) && (boot_mode == RBMS_BOOT_BYTE);
    assign CORE_RUN = (state_reg == RBMS_ST_RUN);
    assign BYTE_DMA_SW_GO = sw_go_reg;

    // ****************************************************************
    // Configuration and bus routing
    // ****************************************************************
    // Host port replaces external buses
    assign CORE_CFG.host_port_cfg = strap_reg.mode_c;
    assign CORE_CFG.ack_open_drain = strap_reg.mode_c & strap_reg.mode_d;
    assign CORE_CFG.start_addr = '0;
    assign HOST_PORT_EN = !cap_pend_reg && strap_reg.mode_c;
    assign EXT_BUS_EN = !cap_pend_reg && !strap_reg.mode_c;

    assign EXT_ADDR = CORE_PM_SEL ? PROGRAM_ADDR_BUS : DATA_ADDR_BUS;
    assign EXT_DATA = CORE_PM_SEL ? PROGRAM_DATA_BUS : DATA_MEM_DATA_BUS;

    // Acknowledge drive per strap D
    // Active drive with strap D low, open-drain with strap D high
    always_comb begin
        HOST_ACCESS_ACK_O = HOST_ACK_REQ;
        HOST_ACCESS_ACK_OE = 1'b0;
        if (HOST_PORT_EN) begin
            if (strap_reg.mode_d) begin
                HOST_ACCESS_ACK_O = 1'b1;
                HOST_ACCESS_ACK_OE = HOST_ACK_REQ;
            end else begin
                HOST_ACCESS_ACK_OE = 1'b1;
            end
        end
    end

    assign SHARED_FLAG_PIN_O = flag_out_reg;
    assign SHARED_FLAG_PIN_OE = flag_oe_reg && !cap_pend_reg;

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;

    assign S_AXI_AWREADY = !aw_hold_reg && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_hold_reg && !S_AXI_BVALID;
    assign wr_fire = aw_hold_reg && w_hold_reg && !S_AXI_BVALID;

    // Catch address and data in either order
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RBMS_RESP_OK;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (awaddr_reg == `RBMS_CTRL_OFF || awaddr_reg == `RBMS_FLAG_OFF) ?
                    `RBMS_RESP_OK : `RBMS_RESP_ERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Register writes: software start pulse and flag control
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sw_go_reg <= 1'b0;
            flag_out_reg <= 1'b0;
            flag_oe_reg <= 1'b0;
        end else begin
            sw_go_reg <= 1'b0;
            if (wr_fire && wstrb_reg[0]) begin
                if (awaddr_reg == `RBMS_CTRL_OFF) begin
                    sw_go_reg <= wdata_reg[`RBMS_CTRL_BYTE_GO];
                end
                if (awaddr_reg == `RBMS_FLAG_OFF) begin
                    flag_out_reg <= wdata_reg[`RBMS_FLAG_OUT];
                    flag_oe_reg <= wdata_reg[`RBMS_FLAG_OE];
                end
            end
        end
    end

    // Read channel, one cycle answer
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= `RBMS_RESP_OK;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `RBMS_RESP_OK;
            unique case (S_AXI_ARADDR)
                `RBMS_CTRL_OFF: S_AXI_RDATA <= '0;
                `RBMS_STAT_OFF: S_AXI_RDATA <= {15'h0000, word_cnt_reg, 1'b0, state_reg, 1'b0,
                    boot_mode == RBMS_BOOT_BAD, 1'b0, strap_reg};
                `RBMS_FLAG_OFF: S_AXI_RDATA <= {29'h0000_0000, SHARED_FLAG_PIN_I, flag_oe_reg, flag_out_reg};
                default: begin
                    S_AXI_RDATA <= '0;
                    S_AXI_RRESP <= `RBMS_RESP_ERR;
                end
            endcase
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_strap_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        !cap_pend_reg && !$past(cap_pend_reg) |-> $stable(strap_reg))
        else $error("strap latch changed after capture");
    a_no_boot_run: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        state_reg == RBMS_ST_WAIT && boot_mode == RBMS_BOOT_NONE |=> CORE_RUN)
        else $error("no-boot mode did not start");
    a_byte_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        CORE_RUN && boot_mode == RBMS_BOOT_BYTE |-> word_cnt_reg == 6'(BOOT_WORDS))
        else $error("ran before all boot words");
    a_host_wait: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        state_reg == RBMS_ST_WAIT && boot_mode == RBMS_BOOT_HOST && !HOST_PM0_WRITE |=> !CORE_RUN)
        else $error("host boot ran early");
    a_boot_req: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        boot_mode == RBMS_BOOT_NONE |-> !BYTE_DMA_BOOT_REQ)
        else $error("boot copy requested in no-boot mode");
    a_ack_drive: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        HOST_PORT_EN && !strap_reg.mode_d |-> HOST_ACCESS_ACK_OE && HOST_ACCESS_ACK_O == HOST_ACK_REQ)
        else $error("acknowledge not actively driven");
    a_ack_open: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        HOST_ACCESS_ACK_OE && strap_reg.mode_d |-> HOST_ACCESS_ACK_O)
        else $error("acknowledge driven low in open-drain form");
    a_port_mux: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        !cap_pend_reg |-> HOST_PORT_EN != EXT_BUS_EN)
        else $error("bus configuration ambiguous");

endmodule : rbms_top

// ==== bench/rbms_boot_mem.sv ====
// Byte boot memory model: one word per request gap.
// Assumes the block's clock and reset.
`timescale 1ns/1ps
module rbms_boot_mem (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic boot_req,
    input wire logic [3:0] gap,
    output logic word_done,
    output logic [7:0] words
);
    logic [3:0] wait_cnt;
    // Word pacing while boot requested
    // Words only on request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 4'h0;
            word_done <= 1'b0;
            words <= 8'h00;
        end else begin
            word_done <= 1'b0;
            if (boot_req && !word_done && wait_cnt >= gap) begin
                word_done <= 1'b1;
                wait_cnt <= 4'h0;
                words <= words + 8'h01;
            end else if (boot_req) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule : rbms_boot_mem

// ==== bench/tb.sv ====
// Testbench for the boot mode selector: every strap mode, flag, ack, buses, registers.
// Assumes the boot memory model beside it.
`timescale 1ns/1ps
module tb;
    import rbms_pkg::*;
    logic clk = 0, rst_b = 0, ma = 0, mb = 0, md = 0, flag_ext = 0, ack_req = 0, pm0 = 0, pm_sel = 0;
    logic [15:0] pa = 16'h1111, da = 16'h2222, pd = 16'h3333, dd = 16'h4444;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [1:0] rs;
    logic [3:0] gap = 0;
    wire logic flag_o, flag_oe, done, boot_req, sw_go, ack_o, ack_oe, run, ext_en, hp_en;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] ea, ed;
    wire logic [7:0] words;
    wire rbms_cfg_s cfg;
    // Flag pin level: block drives or the strap driver does
    wire logic flag_pin = flag_oe ? flag_o : flag_ext;
    int fail_count = 0, compares = 0, go_cnt = 0;
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (sw_go) go_cnt <= go_cnt + 1;
    rbms_top #(.BOOT_WORDS(32)) uut (.CORE_CLK(clk), .RST_B(rst_b), .MODE_A(ma), .MODE_B(mb),
        .MODE_D(md), .SHARED_FLAG_PIN_I(flag_pin), .SHARED_FLAG_PIN_O(flag_o), .SHARED_FLAG_PIN_OE(flag_oe),
        .BYTE_DMA_WORD_DONE(done), .BYTE_DMA_BOOT_REQ(boot_req), .BYTE_DMA_SW_GO(sw_go),
        .HOST_PM0_WRITE(pm0), .HOST_ACK_REQ(ack_req), .HOST_ACCESS_ACK_O(ack_o),
        .HOST_ACCESS_ACK_OE(ack_oe), .CORE_CFG(cfg), .CORE_RUN(run), .CORE_PM_SEL(pm_sel),
        .PROGRAM_ADDR_BUS(pa), .DATA_ADDR_BUS(da), .PROGRAM_DATA_BUS(pd), .DATA_MEM_DATA_BUS(dd),
        .EXT_ADDR(ea), .EXT_DATA(ed), .EXT_BUS_EN(ext_en), .HOST_PORT_EN(hp_en),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));
    rbms_boot_mem mem (.clk(clk), .rst_b(rst_b), .boot_req(boot_req), .gap(gap), .word_done(done),
        .words(words));
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) chk(0, 1);
        #1;
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rs = rresp;
                rd = rdata;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) chk(0, 1);
        #1;
    endtask : axi_rd
    // Reset with straps, then turn the pins round
    task automatic boot(input logic c, b, a, d, input logic [3:0] g);
        @(posedge clk);
        rst_b <= 1'b0;
        {flag_ext, mb, ma, md, gap} <= {c, b, a, d, g};
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        {flag_ext, mb, ma, md} <= {~c, ~b, ~a, ~d};
    endtask : boot
    task automatic wait_run(input int n);
        for (int i = 0; i < n && run !== 1'b1; i++) @(posedge clk);
        #1;
    endtask : wait_run
    task automatic chk_bus(input logic hp);
        @(posedge clk);
        pm_sel <= 1'b1;
        #1;
        chk({ext_en, hp_en}, hp ? 2'b01 : 2'b10);
        if (!hp) chk({ea, ed}, {pa, pd});
        @(posedge clk);
        pm_sel <= 1'b0;
        #1;
        if (!hp) chk({ea, ed}, {da, dd});
    endtask : chk_bus
    // ****
    // Scenarios
    // ****
    task automatic t_byte(input logic c, d, input logic [3:0] g);
        boot(c, 0, 0, d, g);
        wait_run(300);
        chk(words, 32);
        chk({run, boot_req}, 2'b10);
        chk(cfg, {c, c & d, 16'h0000});
        chk_bus(c);
    endtask : t_byte
    task automatic t_none;
        boot(0, 1, 0, 1, 0);
        wait_run(2);
        chk(cfg, {1'b0, 1'b0, 16'h0000});
        chk(run, 1);
        axi_wr(12'h000, 32'h0000_0001);
        chk(go_cnt, 1);
        chk(words, 0);
        axi_rd(12'h004);
        chk({rs, rd[9:7], rd[2:0]}, {2'b00, 3'b100, 3'b010});
        axi_wr(12'h008, 32'h0000_0003);
        chk({flag_oe, flag_o}, 2'b11);
        axi_rd(12'h008);
        chk(rd[2], 1);
        axi_wr(12'h008, 32'h0000_0000);
        axi_rd(12'h008);
        chk({flag_oe, rd[2]}, {1'b0, flag_ext});
        axi_rd(12'h00C);
        chk({rs, rd}, {2'b10, 32'h0000_0000});
        axi_wr(12'h00C, 32'h0000_0001);
        chk(rs, 2'b10);
        chk_bus(0);
    endtask : t_none
    task automatic t_host(input logic d);
        boot(1, 0, 1, d, 0);
        repeat (20) @(posedge clk);
        #1;
        chk({run, words}, 0);
        chk(cfg, {1'b1, d, 16'h0000});
        chk_bus(1);
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            ack_req <= r[0];
            #1;
            chk(ack_oe ? ack_o : 1'b0, r);
            chk(ack_oe, d ? r[0] : 1'b1);
        end
        @(posedge clk);
        pm0 <= 1'b1;
        @(posedge clk);
        pm0 <= 1'b0;
        wait_run(3);
        chk(run, 1);
    endtask : t_host
    task automatic t_bad;
        boot(0, 1, 1, 0, 0);
        repeat (50) @(posedge clk);
        axi_rd(12'h004);
        chk({run, rd[5]}, 2'b01);
    endtask : t_bad
    initial begin
        t_byte(0, 1, 0);
        t_byte(1, 0, 3);
        t_byte(1, 1, 0);
        t_none;
        t_host(0);
        t_host(1);
        t_bad;
        print_verdict;
    end
    // Watchdog against a hang
    initial begin
        #20000;
        fail_count++;
        print_verdict;
    end
endmodule : tb
